// ### inc/i2mt_cfg.svh
`ifndef I2MT_CFG_SVH
`define I2MT_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define I2MT_OFF_CTRL2      4'h0
`define I2MT_OFF_BUF        4'h1
`define I2MT_OFF_STAT       4'h2
`define I2MT_OFF_IRQ_ST     4'h3
`define I2MT_OFF_IRQ_MSK    4'h4
`define I2MT_OFF_BAUD       4'h5

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define I2MT_CTRL_START     0
`define I2MT_CTRL_RESTART   1
`define I2MT_CTRL_STOP      2
`define I2MT_CTRL_ACK       6
`define I2MT_STAT_FULL      0
`define I2MT_STAT_COLL      1
`define I2MT_IRQ_PHASE      0
`define I2MT_IRQ_COLL       1
`define I2MT_IRQ_NB         2

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define I2MT_BAUD_RST       8'h18
`define I2MT_MSK_RST        2'h0
`define I2MT_LAST_BIT       4'h7
`define I2MT_ACK_BIT        4'h8

`endif

// ### inc/i2mt_pkg.sv
`default_nettype none

package i2mt_pkg;

  // ----------------------------------------------------------------------
  // bus sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_STA_SETUP,
    ST_STA_HOLD,
    ST_WAIT,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_RS_REL,
    ST_RS_HIGH,
    ST_SP_LOW,
    ST_SP_HIGH,
    ST_SP_REL
  } i2mt_state_t;

endpackage

`default_nettype wire

// ### src/i2mt_brg.sv
`timescale 1ns/1ns
`default_nettype none

module i2mt_brg (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // control
  input  wire logic       run_in,
  input  wire logic [7:0] reload_in,
  // rollover pulse
  output logic            tick_out
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // stopped counter sits at reload so every phase starts a full period
  always_comb
  begin
    tick_out = run_in && (cnt_r == 8'h00);
    if (!run_in || tick_out)
      cnt_nxt = reload_in;
    else
      cnt_nxt = cnt_r - 8'h01;
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end

endmodule // i2mt_brg

`default_nettype wire

// ### src/i2mt_top.sv
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "i2mt_cfg.svh"

// How it works
// - the acknowledge status flag reads 0 when the slave pulled the ack bit low and 1 otherwise.
// - setting the start request bit in control register two while idle makes a Start condition.
// - the phase interrupt flag is set once the Start condition is finished on the bus.
// - after a Start the data line is held low one full baud period before the clock falls.
// - writing the buffer while waiting starts shifting the eight address bits out at once.
// - after eight bits the slave acknowledge is sampled into the acknowledge status flag.
// - the phase interrupt flag is set at the end of the ninth clock of every byte.
// - each further buffer write sends one more byte with acknowledge capture and interrupt.
// - stop and restart requests make their condition and set the interrupt when done.
// - a buffer write during any running sequence sets write collision and is dropped.
// - buffer full sets on an accepted write and clears when the eighth bit is out.
// - clock low and high phases last one baud period; outside Start, restart and Stop conditions data moves only while clock is low.
// - after the ninth clock the baud counter stops and the clock stays low until a new byte, a stop or a restart.
module i2mt_top (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // register port
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // two-wire bus, open drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // interrupt
  output logic            irq_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic i2mt_hit(input logic [3:0] a, input logic [3:0] off);
    i2mt_hit = (a == off);
  endfunction

  // set beats clear so an event in the clearing cycle survives
  function automatic logic i2mt_w1c(input logic old, input logic set, input logic clr);
    i2mt_w1c = set | (old & ~clr);
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  i2mt_pkg::i2mt_state_t state_r;
  i2mt_pkg::i2mt_state_t state_nxt;
  logic [3:0]            bit_r;
  logic [3:0]            bit_nxt;
  logic [7:0]            shift_r;
  logic [7:0]            shift_nxt;
  logic                  scl_oe_r;
  logic                  scl_oe_nxt;
  logic                  sda_oe_r;
  logic                  sda_oe_nxt;
  logic                  start_req_r;
  logic                  start_req_nxt;
  logic                  rs_req_r;
  logic                  rs_req_nxt;
  logic                  sp_req_r;
  logic                  sp_req_nxt;
  logic                  ack_r;
  logic                  ack_nxt;
  logic                  buffer_full_flag_r;
  logic                  buffer_full_flag_nxt;
  logic                  write_collision_flag_r;
  logic                  write_collision_flag_nxt;
  logic [7:0]            buf_r;
  logic [7:0]            buf_nxt;
  logic [`I2MT_IRQ_NB-1:0] irq_st_r;
  logic [`I2MT_IRQ_NB-1:0] irq_st_nxt;
  logic [`I2MT_IRQ_NB-1:0] irq_set;
  logic [`I2MT_IRQ_NB-1:0] irq_clr;
  logic [`I2MT_IRQ_NB-1:0] mask_r;
  logic [`I2MT_IRQ_NB-1:0] mask_nxt;
  logic [7:0]            baud_r;
  logic [7:0]            baud_nxt;
  logic [7:0]            rdata_r;
  logic [7:0]            rdata_nxt;
  logic                  irq_r;
  logic                  irq_nxt;
  logic                  tick;
  logic                  brg_run;
  logic                  phase_done;
  logic                  sta_done;
  logic                  sp_done;
  logic                  ack_smp;
  logic                  full_clr;
  logic                  wr_ctrl;
  logic                  wr_buf;
  logic                  buf_ok;
  logic                  collide_evt;
  logic                  any_req;

  // ----------------------------------------------------------------------
  // baud rate generator
  // ----------------------------------------------------------------------
  // counter is held at reload while scl is released but still held low by a slave
  assign brg_run = (state_r != i2mt_pkg::ST_IDLE) && (state_r != i2mt_pkg::ST_WAIT) &&
                   !(!scl_oe_r && !scl_in);

  i2mt_brg u_brg (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .run_in    (brg_run),
    .reload_in (baud_r),
    .tick_out  (tick)
  );

  // ----------------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------------
  assign wr_ctrl  = reg_wr_in && i2mt_hit(reg_addr_in, `I2MT_OFF_CTRL2);
  assign wr_buf   = reg_wr_in && i2mt_hit(reg_addr_in, `I2MT_OFF_BUF);
  assign any_req  = start_req_r || rs_req_r || sp_req_r;
  assign buf_ok   = wr_buf && (state_r == i2mt_pkg::ST_WAIT) && !any_req &&
                    !buffer_full_flag_r;
  assign collide_evt = wr_buf && (state_r != i2mt_pkg::ST_IDLE) && !buf_ok;

  always_comb
  begin
    state_nxt  = state_r;
    bit_nxt    = bit_r;
    shift_nxt  = buf_ok ? reg_wdata_in : shift_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    phase_done = 1'b0;
    sta_done   = 1'b0;
    sp_done    = 1'b0;
    ack_smp    = 1'b0;
    full_clr   = 1'b0;
    case (state_r)
      i2mt_pkg::ST_IDLE:
      begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        if (start_req_r)
          state_nxt = i2mt_pkg::ST_STA_SETUP;
      end
      i2mt_pkg::ST_STA_SETUP:
      begin
        if (tick)
        begin
          sda_oe_nxt = 1'b1;
          state_nxt  = i2mt_pkg::ST_STA_HOLD;
        end
      end
      i2mt_pkg::ST_STA_HOLD:
      begin
        // clock falls only after a full hold period with data low
        if (tick)
        begin
          scl_oe_nxt = 1'b1;
          phase_done = 1'b1;
          sta_done   = 1'b1;
          state_nxt  = i2mt_pkg::ST_WAIT;
        end
      end
      i2mt_pkg::ST_WAIT:
      begin
        scl_oe_nxt = 1'b1;
        if (buffer_full_flag_r)
        begin
          bit_nxt   = 4'h0;
          state_nxt = i2mt_pkg::ST_BIT_LOW;
        end
        else if (sp_req_r)
          state_nxt = i2mt_pkg::ST_SP_LOW;
        else if (rs_req_r)
          state_nxt = i2mt_pkg::ST_RS_REL;
      end
      i2mt_pkg::ST_BIT_LOW:
      begin
        // data follows one cycle after the clock went low
        sda_oe_nxt = (bit_r == `I2MT_ACK_BIT) ? 1'b0 : ~shift_r[7];
        if (tick)
        begin
          scl_oe_nxt = 1'b0;
          state_nxt  = i2mt_pkg::ST_BIT_HIGH;
        end
      end
      i2mt_pkg::ST_BIT_HIGH:
      begin
        if (tick && (bit_r == `I2MT_ACK_BIT))
        begin
          ack_smp    = 1'b1;
          scl_oe_nxt = 1'b1;
          phase_done = 1'b1;
          state_nxt  = i2mt_pkg::ST_WAIT;
        end
        else if (tick)
        begin
          shift_nxt  = {shift_r[6:0], 1'b0};
          bit_nxt    = bit_r + 4'h1;
          scl_oe_nxt = 1'b1;
          full_clr   = (bit_r == `I2MT_LAST_BIT);
          state_nxt  = i2mt_pkg::ST_BIT_LOW;
        end
      end
      i2mt_pkg::ST_RS_REL:
      begin
        sda_oe_nxt = 1'b0;
        if (tick)
        begin
          scl_oe_nxt = 1'b0;
          state_nxt  = i2mt_pkg::ST_RS_HIGH;
        end
      end
      i2mt_pkg::ST_RS_HIGH:
      begin
        if (tick)
        begin
          sda_oe_nxt = 1'b1;
          state_nxt  = i2mt_pkg::ST_STA_HOLD;
        end
      end
      i2mt_pkg::ST_SP_LOW:
      begin
        sda_oe_nxt = 1'b1;
        if (tick)
        begin
          scl_oe_nxt = 1'b0;
          state_nxt  = i2mt_pkg::ST_SP_HIGH;
        end
      end
      i2mt_pkg::ST_SP_HIGH:
      begin
        if (tick)
        begin
          sda_oe_nxt = 1'b0;
          state_nxt  = i2mt_pkg::ST_SP_REL;
        end
      end
      i2mt_pkg::ST_SP_REL:
      begin
        if (tick)
        begin
          phase_done = 1'b1;
          sp_done    = 1'b1;
          state_nxt  = i2mt_pkg::ST_IDLE;
        end
      end
      default:
      begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        state_nxt  = i2mt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r  <= i2mt_pkg::ST_IDLE;
      bit_r    <= 4'h0;
      shift_r  <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      bit_r    <= bit_nxt;
      shift_r  <= shift_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  assign irq_set = {collide_evt, phase_done};
  assign irq_clr = (reg_wr_in && i2mt_hit(reg_addr_in, `I2MT_OFF_IRQ_ST)) ?
                   reg_wdata_in[`I2MT_IRQ_NB-1:0] : {`I2MT_IRQ_NB{1'b0}};

  // status bits stay set until software writes a one; hardware never clears them
  genvar gi;
  generate
    for (gi = 0; gi < `I2MT_IRQ_NB; gi = gi + 1)
    begin : g_irq
      assign irq_st_nxt[gi] = i2mt_w1c(irq_st_r[gi], irq_set[gi], irq_clr[gi]);
    end
  endgenerate

  always_comb
  begin
    // requests are only taken where they can run; no queuing of events
    start_req_nxt = (start_req_r && !sta_done) ||
                    (wr_ctrl && (state_r == i2mt_pkg::ST_IDLE) &&
                     reg_wdata_in[`I2MT_CTRL_START]);
    sp_req_nxt    = (sp_req_r && !sp_done) ||
                    (wr_ctrl && (state_r == i2mt_pkg::ST_WAIT) && !buffer_full_flag_r &&
                     !any_req && reg_wdata_in[`I2MT_CTRL_STOP]);
    rs_req_nxt    = (rs_req_r && !sta_done) ||
                    (wr_ctrl && (state_r == i2mt_pkg::ST_WAIT) && !buffer_full_flag_r &&
                     !any_req && reg_wdata_in[`I2MT_CTRL_RESTART] &&
                     !reg_wdata_in[`I2MT_CTRL_STOP]);
    ack_nxt       = ack_smp ? sda_in : ack_r;
    buffer_full_flag_nxt = buf_ok | (buffer_full_flag_r & ~full_clr);
    write_collision_flag_nxt = i2mt_w1c(write_collision_flag_r, collide_evt,
                                        reg_wr_in && i2mt_hit(reg_addr_in, `I2MT_OFF_STAT) &&
                                        reg_wdata_in[`I2MT_STAT_COLL]);
    buf_nxt       = (buf_ok || (wr_buf && (state_r == i2mt_pkg::ST_IDLE))) ?
                    reg_wdata_in : buf_r;
    mask_nxt      = (reg_wr_in && i2mt_hit(reg_addr_in, `I2MT_OFF_IRQ_MSK)) ?
                    reg_wdata_in[`I2MT_IRQ_NB-1:0] : mask_r;
    baud_nxt      = (reg_wr_in && i2mt_hit(reg_addr_in, `I2MT_OFF_BAUD)) ?
                    reg_wdata_in : baud_r;
    irq_nxt       = |(irq_st_nxt & mask_nxt);
    rdata_nxt     = 8'h00;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `I2MT_OFF_CTRL2:   rdata_nxt = {1'b0, ack_r, 3'h0, sp_req_r, rs_req_r, start_req_r};
        `I2MT_OFF_BUF:     rdata_nxt = buf_r;
        `I2MT_OFF_STAT:    rdata_nxt = {6'h00, write_collision_flag_r, buffer_full_flag_r};
        `I2MT_OFF_IRQ_ST:  rdata_nxt = {6'h00, irq_st_r};
        `I2MT_OFF_IRQ_MSK: rdata_nxt = {6'h00, mask_r};
        `I2MT_OFF_BAUD:    rdata_nxt = baud_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      start_req_r <= 1'b0;
      rs_req_r    <= 1'b0;
      sp_req_r    <= 1'b0;
      ack_r       <= 1'b0;
      buffer_full_flag_r     <= 1'b0;
      write_collision_flag_r <= 1'b0;
      buf_r       <= 8'h00;
      irq_st_r    <= {`I2MT_IRQ_NB{1'b0}};
      mask_r      <= `I2MT_MSK_RST;
      baud_r      <= `I2MT_BAUD_RST;
      rdata_r     <= 8'h00;
      irq_r       <= 1'b0;
    end
    else
    begin
      start_req_r <= start_req_nxt;
      rs_req_r    <= rs_req_nxt;
      sp_req_r    <= sp_req_nxt;
      ack_r       <= ack_nxt;
      buffer_full_flag_r     <= buffer_full_flag_nxt;
      write_collision_flag_r <= write_collision_flag_nxt;
      buf_r       <= buf_nxt;
      irq_st_r    <= irq_st_nxt;
      mask_r      <= mask_nxt;
      baud_r      <= baud_nxt;
      rdata_r     <= rdata_nxt;
      irq_r       <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // open drain: the pin value is always low, only the enable moves
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  assign scl_oe_out    = scl_oe_r;
  assign sda_oe_out    = sda_oe_r;
  assign reg_rdata_out = rdata_r;
  assign irq_out       = irq_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_ack_capture;
    ack_smp |=> (ack_r == $past(sda_in));
  endproperty
  a_ack_capture: assert property (p_ack_capture) else $error("ack flag not from sda");

  property p_start_go;
    (wr_ctrl && reg_wdata_in[`I2MT_CTRL_START] && (state_r == i2mt_pkg::ST_IDLE))
      |=> ##1 (state_r == i2mt_pkg::ST_STA_SETUP) && !scl_oe_r && !sda_oe_r;
  endproperty
  a_start_go: assert property (p_start_go) else $error("start request not taken");

  property p_start_irq;
    ((state_r == i2mt_pkg::ST_STA_HOLD) && tick) |=> irq_st_r[`I2MT_IRQ_PHASE] && scl_oe_r;
  endproperty
  a_start_irq: assert property (p_start_irq) else $error("no irq after start");

  property p_start_hold;
    ($rose(sda_oe_r) && !scl_oe_r) |-> (!scl_oe_r)[*2];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start hold too short");

  property p_byte_go;
    buf_ok |=> buffer_full_flag_r ##1 (state_r == i2mt_pkg::ST_BIT_LOW) && (bit_r == 4'h0);
  endproperty
  a_byte_go: assert property (p_byte_go) else $error("buffer write did not start byte");

  property p_collide;
    collide_evt |=> write_collision_flag_r && irq_st_r[`I2MT_IRQ_COLL] &&
      (buf_r == $past(buf_r));
  endproperty
  a_collide: assert property (p_collide) else $error("collision lost or buffer moved");

  property p_full_clear;
    $fell(buffer_full_flag_r) |->
      (bit_r == `I2MT_ACK_BIT) && (state_r == i2mt_pkg::ST_BIT_LOW);
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("buffer full cleared early");

  property p_ninth_irq;
    ((state_r == i2mt_pkg::ST_BIT_HIGH) && (bit_r == `I2MT_ACK_BIT) && tick)
      |=> irq_st_r[`I2MT_IRQ_PHASE] && (state_r == i2mt_pkg::ST_WAIT);
  endproperty
  a_ninth_irq: assert property (p_ninth_irq) else $error("no irq after ninth clock");

  property p_wait_hold;
    (state_r == i2mt_pkg::ST_WAIT) |-> scl_oe_r && !brg_run;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("clock not held while waiting");

  property p_data_low;
    ((state_r == i2mt_pkg::ST_BIT_LOW) || (state_r == i2mt_pkg::ST_BIT_HIGH)) &&
      $changed(sda_oe_r) |-> scl_oe_r && $past(scl_oe_r);
  endproperty
  a_data_low: assert property (p_data_low) else $error("data moved with clock high");

  property p_stop_end;
    ((state_r == i2mt_pkg::ST_SP_REL) && tick)
      |=> (state_r == i2mt_pkg::ST_IDLE) && irq_st_r[`I2MT_IRQ_PHASE] && !sp_req_r;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop did not finish cleanly");

endmodule // i2mt_top

`default_nettype wire

// ### dv/i2mt_slave_model.sv
`timescale 1ns/1ns
`default_nettype none

// --------------------------------
// addressed slave on the two-wire bus
// --------------------------------
module i2mt_slave_model (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // wire levels and behaviour
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       ack_en_in,
  input  wire logic [3:0] stretch_in,
  // pulls and observations
  output logic            scl_pull_out,
  output logic            sda_pull_out,
  output logic      [7:0] byte_out,
  output logic      [7:0] bytes_out,
  output logic      [7:0] starts_out,
  output logic      [7:0] stops_out
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [3:0] hold;
  logic [7:0] sh;

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      {scl_q, sda_q} <= 2'h3;
      {cnt, hold, sh, byte_out, bytes_out, starts_out, stops_out} <= '0;
      {scl_pull_out, sda_pull_out} <= 2'h0;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      // low phase stretched to prove the master waits for the wire
      scl_pull_out <= (hold != 4'h0);
      if (hold != 4'h0)
        hold <= hold - 4'h1;
      if (scl_q && scl_in && sda_q && !sda_in)
      begin
        starts_out <= starts_out + 8'h1;
        cnt        <= 4'h0;
      end
      if (scl_q && scl_in && !sda_q && sda_in)
        stops_out <= stops_out + 8'h1;
      if (!scl_q && scl_in && cnt < 4'h8)
      begin
        sh  <= {sh[6:0], sda_in};
        cnt <= cnt + 4'h1;
      end
      if (scl_q && !scl_in)
      begin
        hold <= stretch_in;
        if (cnt == 4'h8)
        begin
          sda_pull_out <= ack_en_in;
          cnt          <= 4'h9;
          byte_out     <= sh;
          bytes_out    <= bytes_out + 8'h1;
        end
        else if (cnt == 4'h9)
        begin
          sda_pull_out <= 1'b0;
          cnt          <= 4'h0;
        end
      end
    end
  end
endmodule // i2mt_slave_model

`default_nettype wire

// ### dv/i2c_master_transmit_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2mt_cfg.svh"

module i2c_master_transmit_tb;
  logic       mclk, resetn, wr, rd, ack_en;
  logic [3:0] addr, stretch;
  logic [7:0] wdata, rdata, d;
  logic       scl_o, scl_oe, sda_o, sda_oe, irq, scl_pull, sda_pull;
  logic [7:0] s_byte, s_bytes, s_starts, s_stops;
  wire  logic scl_w = (scl_oe ? scl_o : 1'b1) & !scl_pull;
  wire  logic sda_w = (sda_oe ? sda_o : 1'b1) & !sda_pull;
  int         bad_count, checks_done, cyc, n_bytes, n_starts;
  logic [7:0] exp_q[$];

  i2mt_top uut (.mclk_in(mclk), .resetn_in(resetn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .irq_out(irq));

  i2mt_slave_model slv (.mclk_in(mclk), .resetn_in(resetn), .scl_in(scl_w),
    .sda_in(sda_w), .ack_en_in(ack_en), .stretch_in(stretch),
    .scl_pull_out(scl_pull), .sda_pull_out(sda_pull), .byte_out(s_byte),
    .bytes_out(s_bytes), .starts_out(s_starts), .stops_out(s_stops));

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_phase;
    logic [7:0] v;
    int         k;
    v = 8'h00;
    k = 0;
    while (v[0] !== 1'b1 && k < 400)
    begin
      rreg(`I2MT_OFF_IRQ_ST, v);
      k++;
    end
    chk("phase irq", 8'(v[0]), 8'h01);
  endtask

  task automatic send_byte(input logic [7:0] b, input logic ack, input logic collide);
    logic [7:0] v;
    ack_en  <= ack;
    stretch <= 4'($urandom_range(0, 5));
    exp_q.push_back(b);
    n_bytes++;
    wreg(`I2MT_OFF_BUF, b);
    rreg(`I2MT_OFF_STAT, v); chk("full set", 8'(v[0]), 8'h01);
    if (collide)
    begin
      wreg(`I2MT_OFF_BUF, ~b);
      rreg(`I2MT_OFF_STAT, v); chk("collision", 8'(v[1]), 8'h01);
      rreg(`I2MT_OFF_IRQ_ST, v); chk("collision irq", 8'(v[1]), 8'h01);
      wreg(`I2MT_OFF_STAT, 8'h02);
      wreg(`I2MT_OFF_IRQ_ST, 8'h02);
    end
    wait_phase;
    chk("byte", s_byte, exp_q.pop_front());
    chk("byte count", s_bytes, 8'(n_bytes));
    rreg(`I2MT_OFF_CTRL2, v); chk("ack status", 8'(v[6]), 8'(!ack));
    rreg(`I2MT_OFF_STAT, v); chk("full clear", v, 8'h00);
    chk("scl parked low", 8'(scl_w), 8'h00);
    wreg(`I2MT_OFF_IRQ_ST, 8'h01);
  endtask

  task end_sim;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // --------------------------------
  // clock, timeout, sequence
  // --------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // whole run is around a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      end_sim;
    end
  end

  initial
  begin
    {resetn, wr, rd, addr, wdata, stretch} = '0;
    ack_en = 1'b1;
    {bad_count, checks_done, cyc, n_bytes, n_starts} = '0;
    void'($urandom(32'hC0DF0A7E));
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rreg(`I2MT_OFF_BAUD, d); chk("baud rst", d, `I2MT_BAUD_RST);
    rreg(`I2MT_OFF_IRQ_MSK, d); chk("mask rst", d, 8'h00);
    rreg(`I2MT_OFF_STAT, d); chk("stat rst", d, 8'h00);
    wreg(4'hF, 8'hFF);
    rreg(4'hF, d); chk("unmapped", d, 8'h00);
    wreg(`I2MT_OFF_BAUD, 8'h03);
    rreg(`I2MT_OFF_BAUD, d); chk("baud", d, 8'h03);
    // idle buffer write only stores
    wreg(`I2MT_OFF_BUF, 8'h5A);
    rreg(`I2MT_OFF_BUF, d); chk("buf idle", d, 8'h5A);
    rreg(`I2MT_OFF_STAT, d); chk("no collision idle", 8'(d[1]), 8'h00);
    // start with the phase event masked
    wreg(`I2MT_OFF_CTRL2, 8'h01 << `I2MT_CTRL_START);
    wait_phase;
    n_starts++;
    chk("starts", s_starts, 8'(n_starts));
    chk("irq masked", 8'(irq), 8'h00);
    wreg(`I2MT_OFF_IRQ_MSK, 8'h03);
    @(posedge mclk);
    #1 chk("irq unmasked", 8'(irq), 8'h01);
    wreg(`I2MT_OFF_IRQ_ST, 8'h01);
    @(posedge mclk);
    #1 chk("irq cleared", 8'(irq), 8'h00);
    wreg(`I2MT_OFF_IRQ_MSK, 8'h01);
    send_byte(8'($urandom), 1'b1, 1'b1);
    // a start request while the clock is parked is dropped, not queued
    wreg(`I2MT_OFF_CTRL2, 8'h01 << `I2MT_CTRL_START);
    rreg(`I2MT_OFF_CTRL2, d); chk("start refused", 8'(d[0]), 8'h00);
    for (int i = 0; i < 4; i++)
      send_byte(8'($urandom), i != 1, 1'b0);
    wreg(`I2MT_OFF_CTRL2, 8'h01 << `I2MT_CTRL_RESTART);
    wait_phase;
    n_starts++;
    chk("restarts", s_starts, 8'(n_starts));
    wreg(`I2MT_OFF_IRQ_ST, 8'h01);
    send_byte(8'($urandom), 1'b1, 1'b0);
    // stop and restart asked together: stop wins
    wreg(`I2MT_OFF_CTRL2, (8'h01 << `I2MT_CTRL_STOP) | (8'h01 << `I2MT_CTRL_RESTART));
    wait_phase;
    chk("stops", s_stops, 8'h01);
    chk("stop wins", s_starts, 8'(n_starts));
    rreg(`I2MT_OFF_CTRL2, d); chk("req done", 8'(d[2:0]), 8'h00);
    chk("bus free", 8'({scl_w, sda_w}), 8'h03);
    wreg(`I2MT_OFF_IRQ_ST, 8'h01);
    end_sim;
  end
endmodule // i2c_master_transmit_tb

`default_nettype wire
